// *** mrsd_cfg_if.sv ***
// Carries the stored register fields from the capture logic to the field decoder.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mrsd_cfg_if;
	mrsd_pkg::mrsd_cfg_t cfg;
	modport src (output cfg);
	modport dst (input cfg);
endinterface
`default_nettype wire

// *** mrsd_ctrl_model.sv ***
// Controller model issuing mode register set commands on the pins.
// Assumes the bench clock; all pins change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mrsd_ctrl_model
(
	// Clock
	input wire logic ref_clk,
	// Command pins
	output logic cs_n,
	output logic act_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	// Bank and address
	output logic [1:0] bg,
	output logic [1:0] ba,
	output logic [mrsd_pkg::ADDR_W-1:0] addr
);
	initial
	begin
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
		bg = 2'h0;
		ba = 2'h0;
		addr = 18'h00000;
	end

	// One command for one cycle, then deselect
	task automatic mode_set(input logic [2:0] sel, input logic bg1, input logic [17:0] a);
		@(negedge ref_clk);
		{cs_n, act_n, ras_n, cas_n, we_n} = mrsd_pkg::CMD_MODE_SET;
		{bg, ba} = {bg1, sel};
		addr = a;
		@(negedge ref_clk);
		// Deselected lines show garbage
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
		bg = ~bg;
		ba = ~ba;
		addr = ~addr;
	endtask
endmodule
`default_nettype wire

// *** mrsd_field_decode.sv ***
// Registered decode of the stored fields into cycle counts and reference level.
// Assumes the fields arrive from the capture register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mrsd_field_decode
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Stored fields
	mrsd_cfg_if.dst cfg_in,
	// Decoded results
	output logic [3:0] spacing_cycles,
	output logic [10:0] dll_lock_cycles,
	output logic spacing_reserved,
	output logic training_mode,
	output logic training_range_low,
	output logic [13:0] ref_level,
	output logic ref_code_reserved
);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			spacing_cycles <= mrsd_pkg::mrsd_spacing_of(mrsd_pkg::SPACING_CODE_RST);
			dll_lock_cycles <= mrsd_pkg::mrsd_lock_of(mrsd_pkg::SPACING_CODE_RST);
			spacing_reserved <= 1'b0;
		end
		else
		begin
			spacing_cycles <= mrsd_pkg::mrsd_spacing_of(cfg_in.cfg.spacing_code);
			dll_lock_cycles <= mrsd_pkg::mrsd_lock_of(cfg_in.cfg.spacing_code);
			spacing_reserved <= cfg_in.cfg.spacing_code > mrsd_pkg::SPACING_CODE_MAX;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			training_mode <= 1'b0;
			training_range_low <= 1'b0;
			ref_level <= mrsd_pkg::mrsd_level_of(1'b0, mrsd_pkg::REF_CODE_RST);
			ref_code_reserved <= 1'b0;
		end
		else
		begin
			training_mode <= cfg_in.cfg.train_en;
			training_range_low <= cfg_in.cfg.train_range;
			ref_level <= mrsd_pkg::mrsd_level_of(cfg_in.cfg.train_range, cfg_in.cfg.ref_code);
			ref_code_reserved <= cfg_in.cfg.ref_code > mrsd_pkg::REF_CODE_MAX;
		end
	end

endmodule
`default_nettype wire

// *** mrsd_mode_register_six_decode.sv ***
// Capture and decode of the timing and reference mode register from command pins.
// Assumes command, bank and address pins come from outside and are sampled on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mrsd_mode_register_six_decode
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Command pins
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	// Bank group, bank and address pins
	input wire logic [1:0] bg,
	input wire logic [1:0] ba,
	input wire logic [mrsd_pkg::ADDR_W-1:0] addr,
	// Write status
	output logic config_written,
	output logic reserved_bits_seen,
	// Decoded configuration
	output logic [3:0] spacing_cycles,
	output logic [10:0] dll_lock_cycles,
	output logic spacing_reserved,
	output logic training_mode,
	output logic training_range_low,
	output logic [13:0] ref_level,
	output logic ref_code_reserved
);

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	logic [mrsd_pkg::PIN_W-1:0] pin_s1_reg;
	logic [mrsd_pkg::PIN_W-1:0] pin_s2_reg;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pin_s1_reg <= '1;
			pin_s2_reg <= '1;
		end
		else
		begin
			pin_s1_reg <= {cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic [4:0] cmd_s;
	logic bg1_s;
	logic [2:0] sel_s;
	logic [mrsd_pkg::ADDR_W-1:0] addr_s;
	logic mode_set;
	logic hit_this;

	assign cmd_s = pin_s2_reg[mrsd_pkg::PIN_W-1 -: 5];
	assign bg1_s = pin_s2_reg[mrsd_pkg::ADDR_W+3];
	assign sel_s = pin_s2_reg[mrsd_pkg::ADDR_W+2 -: 3];
	assign addr_s = pin_s2_reg[mrsd_pkg::ADDR_W-1:0];
	assign mode_set = cmd_s == mrsd_pkg::CMD_MODE_SET;
	// Select 111 (control word, also the eighth register) falls through here
	assign hit_this = mode_set && sel_s == mrsd_pkg::SEL_TIMING_VREF;

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	mrsd_cfg_if cfg_bus ();
	mrsd_pkg::mrsd_cfg_t cfg_reg;
	mrsd_pkg::mrsd_cfg_t cfg_next;

	always_comb
	begin
		cfg_next.spacing_code = addr_s[mrsd_pkg::SPACING_HI:mrsd_pkg::SPACING_LO];
		cfg_next.train_en = addr_s[mrsd_pkg::TRAIN_EN_BIT];
		cfg_next.train_range = addr_s[mrsd_pkg::TRAIN_RANGE_BIT];
		cfg_next.ref_code = addr_s[mrsd_pkg::REF_CODE_HI:mrsd_pkg::REF_CODE_LO];
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cfg_reg <= '{mrsd_pkg::SPACING_CODE_RST, 1'b0, 1'b0, mrsd_pkg::REF_CODE_RST};
		else if (hit_this)
			cfg_reg <= cfg_next;
	end

	assign cfg_bus.cfg = cfg_reg;

	// Write strobe and reserved bit check, informative only
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			config_written <= 1'b0;
			reserved_bits_seen <= 1'b0;
		end
		else
		begin
			config_written <= hit_this;
			if (hit_this)
				reserved_bits_seen <= bg1_s || |(addr_s & mrsd_pkg::RSVD_ADDR_MASK);
		end
	end

	// ----------------------------------------
	// Field decoder
	// ----------------------------------------
	mrsd_field_decode u_decode
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.cfg_in(cfg_bus),
		.spacing_cycles(spacing_cycles),
		.dll_lock_cycles(dll_lock_cycles),
		.spacing_reserved(spacing_reserved),
		.training_mode(training_mode),
		.training_range_low(training_range_low),
		.ref_level(ref_level),
		.ref_code_reserved(ref_code_reserved)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_select_capture: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this |=> cfg_reg == $past(cfg_next))
		else $error("register not captured on its select");

	a_control_word_ignored: assert property (@(posedge ref_clk) disable iff (rst)
		(mode_set && sel_s == mrsd_pkg::SEL_CONTROL_WORD) |=> $stable(cfg_reg) && !config_written)
		else $error("control word select altered state");

	a_other_select_ignored: assert property (@(posedge ref_clk) disable iff (rst)
		!hit_this |=> $stable(cfg_reg) ##1 $stable(training_mode) && $stable(ref_level))
		else $error("foreign select changed outputs");

	a_spacing_table: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && addr_s[mrsd_pkg::SPACING_HI:mrsd_pkg::SPACING_LO] == 3'h3
		|=> ##1 spacing_cycles == 4'h7 && !spacing_reserved)
		else $error("spacing code 011 not seven cycles");

	a_lock_table: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && addr_s[mrsd_pkg::SPACING_HI:mrsd_pkg::SPACING_LO] == 3'h2
		|=> ##1 dll_lock_cycles == 11'h300)
		else $error("lock time for code 010 wrong");

	a_training_enable: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this |=> ##1 training_mode == $past(addr_s[mrsd_pkg::TRAIN_EN_BIT], 2))
		else $error("training enable not applied");

	a_training_range: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this |=> ##1 training_range_low == $past(addr_s[mrsd_pkg::TRAIN_RANGE_BIT], 2))
		else $error("training range not applied");

	a_ref_level: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && !addr_s[mrsd_pkg::TRAIN_RANGE_BIT]
		&& addr_s[mrsd_pkg::REF_CODE_HI:mrsd_pkg::REF_CODE_LO] == 6'h32
		|=> ##1 ref_level == 14'h2422 && !ref_code_reserved)
		else $error("top code not 92.50 percent");

	a_write_strobe: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this |=> config_written)
		else $error("accepted write gave no strobe");

	a_no_stray_strobe: assert property (@(posedge ref_clk) disable iff (rst)
		!hit_this |=> !config_written)
		else $error("strobe without an accepted write");

	a_reserved_set: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && (bg1_s || (addr_s & mrsd_pkg::RSVD_ADDR_MASK) != '0)
		|=> reserved_bits_seen)
		else $error("reserved bit write not flagged");

	a_reserved_clear: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && !bg1_s && (addr_s & mrsd_pkg::RSVD_ADDR_MASK) == '0
		|=> !reserved_bits_seen)
		else $error("clean write left reserved flag set");

	a_reserved_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!hit_this |=> $stable(reserved_bits_seen))
		else $error("reserved flag moved without a write");

	a_spacing_lowest: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && addr_s[mrsd_pkg::SPACING_HI:mrsd_pkg::SPACING_LO] == 3'h0
		|=> ##1 spacing_cycles == 4'h4 && dll_lock_cycles == 11'h255)
		else $error("code 000 not four cycles and 597 lock");

	a_spacing_second: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && addr_s[mrsd_pkg::SPACING_HI:mrsd_pkg::SPACING_LO] == 3'h1
		|=> ##1 spacing_cycles == 4'h5 && dll_lock_cycles == 11'h255)
		else $error("code 001 not five cycles");

	a_spacing_highest: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && addr_s[mrsd_pkg::SPACING_HI:mrsd_pkg::SPACING_LO] == 3'h4
		|=> ##1 spacing_cycles == 4'h8 && dll_lock_cycles == 11'h400)
		else $error("code 100 not eight cycles");

	a_spacing_reserved: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this
		&& addr_s[mrsd_pkg::SPACING_HI:mrsd_pkg::SPACING_LO] > mrsd_pkg::SPACING_CODE_MAX
		|=> ##1 spacing_reserved && spacing_cycles == 4'h0
		&& dll_lock_cycles == 11'h000)
		else $error("reserved spacing code not flagged");

	a_level_low_base: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this && addr_s[mrsd_pkg::TRAIN_RANGE_BIT]
		&& addr_s[mrsd_pkg::REF_CODE_HI:mrsd_pkg::REF_CODE_LO] == 6'h00
		|=> ##1 ref_level == 14'h1194)
		else $error("lower range does not start at 45 percent");

	a_code_reserved: assert property (@(posedge ref_clk) disable iff (rst)
		hit_this
		&& addr_s[mrsd_pkg::REF_CODE_HI:mrsd_pkg::REF_CODE_LO] > mrsd_pkg::REF_CODE_MAX
		|=> ##1 ref_code_reserved)
		else $error("code above 110010 not flagged");

	a_decode_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!hit_this |=> ##1 $stable(spacing_cycles) && $stable(dll_lock_cycles)
		&& $stable(training_range_low) && $stable(ref_code_reserved))
		else $error("decoded outputs moved without a write");

endmodule
`default_nettype wire

// *** mrsd_mode_register_six_decode_tb.sv ***
// Self-checking bench for the timing and reference mode register decode.
// Assumes the controller model drives all pins; 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module mrsd_mode_register_six_decode_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n, act_n, ras_n, cas_n, we_n;
	logic [1:0] bg, ba;
	logic [17:0] addr;
	logic cw, rbs, sres, trn, rlow, rres;
	logic [3:0] spc;
	logic [10:0] lock;
	logic [13:0] lvl;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;

	always #20 ref_clk = ~ref_clk;

	mrsd_ctrl_model ctrl (.ref_clk(ref_clk), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr));
	mrsd_mode_register_six_decode uut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
		.act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba),
		.addr(addr), .config_written(cw), .reserved_bits_seen(rbs), .spacing_cycles(spc),
		.dll_lock_cycles(lock), .spacing_reserved(sres), .training_mode(trn),
		.training_range_low(rlow), .ref_level(lvl), .ref_code_reserved(rres));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [17:0] fa(input logic [2:0] sp, input logic t, input logic r,
		input logic [5:0] rc);
		return {5'h00, sp, 2'h0, t, r, rc};
	endfunction

	task automatic wr(input logic [2:0] sel, input logic bg1, input logic [17:0] a);
		ctrl.mode_set(sel, bg1, a);
		repeat (2) @(negedge ref_clk);
		check(cw, sel == 3'h6, "write pulse");
		@(negedge ref_clk);
		check(cw, 32'h0, "pulse width");
	endtask

	task automatic cmp(input logic [2:0] sp, input logic t, input logic r, input logic [5:0] rc);
		logic [31:0] exp_lock;
		exp_lock = sp < 3'h2 ? 32'h255 : sp == 3'h2 ? 32'h300 : sp <= 3'h4 ? 32'h400 : 32'h0;
		check(spc, sp <= 3'h4 ? 32'(sp) + 32'h4 : 32'h0, "spacing");
		check(lock, exp_lock, "lock time");
		check(sres, sp > 3'h4, "spacing reserved");
		check(trn, t, "training");
		check(rlow, r, "range");
		check(lvl, (r ? 32'h1194 : 32'h1770) + 32'h41 * rc, "level");
		check(rres, rc > 6'h32, "code reserved");
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_spacing;
		for (int i = 0; i < 8; i++)
		begin
			wr(3'h6, 1'b0, fa(3'(i), i[0], i[1], 6'(i)));
			cmp(3'(i), i[0], i[1], 6'(i));
		end
		$display("spacing test done");
	endtask

	task automatic t_level;
		logic [5:0] codes[5] = '{6'h00, 6'h01, 6'h32, 6'h33, 6'h3F};
		for (int i = 0; i < 10; i++)
		begin
			wr(3'h6, 1'b0, fa(3'(i % 5), i[0], i >= 5, codes[i % 5]));
			cmp(3'(i % 5), i[0], i >= 5, codes[i % 5]);
		end
		$display("level test done");
	endtask

	task automatic t_ignored;
		wr(3'h6, 1'b0, fa(3'h3, 1'b1, 1'b1, 6'h2A));
		for (int s = 0; s < 8; s++)
		begin
			if (s != 6)
			begin
				wr(3'(s), 1'b0, fa(3'h1, 1'b0, 1'b0, 6'h05));
				cmp(3'h3, 1'b1, 1'b1, 6'h2A);
			end
		end
		$display("ignored select test done");
	endtask

	task automatic t_reserved;
		logic [4:0] pos[4] = '{5'h11, 5'h0D, 5'h09, 5'h08};
		wr(3'h6, 1'b1, fa(3'h1, 1'b0, 1'b1, 6'h05) | mrsd_pkg::RSVD_ADDR_MASK);
		check(rbs, 32'h1, "reserved bits flag");
		cmp(3'h1, 1'b0, 1'b1, 6'h05);
		for (int k = 0; k < 4; k++)
		begin
			wr(3'h6, 1'b0, fa(3'h0, 1'b0, 1'b0, 6'h00));
			check(rbs, 32'h0, "reserved bits clear");
			wr(3'h6, 1'b0, fa(3'h2, 1'b1, 1'b0, 6'h10) | (18'h00001 << pos[k]));
			check(rbs, 32'h1, "single reserved address bit");
			cmp(3'h2, 1'b1, 1'b0, 6'h10);
		end
		wr(3'h6, 1'b0, fa(3'h0, 1'b0, 1'b0, 6'h00));
		check(rbs, 32'h0, "reserved bits clear again");
		wr(3'h6, 1'b1, fa(3'h0, 1'b0, 1'b0, 6'h00));
		check(rbs, 32'h1, "reserved bank group bit");
		$display("reserved bits test done");
	endtask

	task automatic t_reset;
		wr(3'h6, 1'b1, fa(3'h4, 1'b1, 1'b1, 6'h20));
		check(rbs, 32'h1, "flag before reset");
		rst = 1'b1;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		cmp(3'h0, 1'b0, 1'b0, 6'h00);
		check(cw, 32'h0, "strobe after reset");
		check(rbs, 32'h0, "flag after reset");
		wr(3'h6, 1'b0, fa(3'h2, 1'b0, 1'b1, 6'h01));
		cmp(3'h2, 1'b0, 1'b1, 6'h01);
		$display("mid-run reset test done");
	endtask

	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			mismatches++;
			end_sim;
		end
	end

	initial
	begin
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
		cmp(3'h0, 1'b0, 1'b0, 6'h00);
		check(cw, 32'h0, "reset pulse");
		check(rbs, 32'h0, "reset flag");
		$display("reset test done");
		t_spacing();
		t_level();
		t_ignored();
		t_reserved();
		t_reset();
		end_sim();
	end
endmodule
`default_nettype wire

// *** mrsd_pkg.sv ***
// Constants, field layout and decode functions for the timing and reference mode register.
// Assumes a single 25 MHz device clock domain.
`default_nettype none
package mrsd_pkg;

	// ----------------------------------------
	// Pin bundle and command encoding
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int PIN_W = 27;
	// Command pins ordered cs_n, act_n, ras_n, cas_n, we_n
	localparam logic [4:0] CMD_MODE_SET = 5'h08;
	localparam logic [2:0] SEL_TIMING_VREF = 3'h6;
	localparam logic [2:0] SEL_CONTROL_WORD = 3'h7;

	// ----------------------------------------
	// Field positions in the address bus
	// ----------------------------------------
	localparam int SPACING_LO = 10;
	localparam int SPACING_HI = 12;
	localparam int TRAIN_EN_BIT = 7;
	localparam int TRAIN_RANGE_BIT = 6;
	localparam int REF_CODE_HI = 5;
	localparam int REF_CODE_LO = 0;
	localparam logic [ADDR_W-1:0] RSVD_ADDR_MASK = 18'h22300;

	// ----------------------------------------
	// Reset values and decode figures
	// ----------------------------------------
	localparam logic [2:0] SPACING_CODE_RST = 3'h0;
	localparam logic [5:0] REF_CODE_RST = 6'h00;
	localparam logic [2:0] SPACING_CODE_MAX = 3'h4;
	localparam logic [3:0] SPACING_BASE = 4'h4;
	localparam logic [10:0] LOCK_LOW = 11'h255;
	localparam logic [10:0] LOCK_MID = 11'h300;
	localparam logic [10:0] LOCK_HIGH = 11'h400;
	localparam logic [2:0] LOCK_MID_CODE = 3'h2;
	localparam logic [2:0] LOCK_HIGH_CODE = 3'h3;
	// Reference level in hundredths of a percent
	localparam logic [13:0] LEVEL_BASE_HIGH = 14'h1770;
	localparam logic [13:0] LEVEL_BASE_LOW = 14'h1194;
	localparam logic [13:0] LEVEL_STEP = 14'h0041;
	localparam logic [5:0] REF_CODE_MAX = 6'h32;

	typedef struct packed {
		logic [2:0] spacing_code;
		logic train_en;
		logic train_range;
		logic [5:0] ref_code;
	} mrsd_cfg_t;

	function automatic logic [3:0] mrsd_spacing_of(input logic [2:0] code);
		if (code > SPACING_CODE_MAX)
			return 4'h0;
		return SPACING_BASE + {1'b0, code};
	endfunction

	function automatic logic [10:0] mrsd_lock_of(input logic [2:0] code);
		if (code > SPACING_CODE_MAX)
			return 11'h000;
		if (code < LOCK_MID_CODE)
			return LOCK_LOW;
		if (code == LOCK_MID_CODE)
			return LOCK_MID;
		return LOCK_HIGH;
	endfunction

	function automatic logic [13:0] mrsd_level_of(input logic low_range, input logic [5:0] code);
		logic [13:0] base;
		base = low_range ? LEVEL_BASE_LOW : LEVEL_BASE_HIGH;
		return base + 14'({8'h00, code} * LEVEL_STEP);
	endfunction

endpackage
`default_nettype wire
